// >>> vacuum_chamber_supervisor.v
// What this block does
// R1: Fault and sensor break set when high gauge status or value is bad.
// R2: High gauge enable is a hysteresis setpoint output from two levels.
// R3: Enable state reads out, disabled after reset, moves only on level crossings.
// R4: Enable compares low gauge or backing gauge, low gauge by default.
// R5: Roughing timeout set if target vacuum not reached when set time elapses.
// R6: Roughing timeout watches low gauge or backing gauge by configuration.
// R7: Timeout lamp flashes until timeout ends, then steady if missed, else off.
// R8: Pumps off, leak detector measures pressure rise per minute.
// R9: At leak timeout end, rate above limit sets leak fault.
// R10: Leak lamp flashes while measuring, steady once fault found.
// R11: Chamber reading blends low and high gauges across the switchover band.
// R12: Reading outside its switchover band used only when other gauge broken.
// R13: Configurer sets enable levels to power high gauge before switchover.
// R14: Chamber output clamped between configured minimum and maximum.
// R15: Timeout and leak lamps shown only when their source is not none.
// R16: On level above off level: on above on level, off below off level.
// R17: Timers and rates count fixed ticks; lamps flash at a tick rate.
`include "vac_sup_regs.vh"
`timescale 1ns/100ps
`default_nettype none

module vacuum_chamber_supervisor #(
   parameter W           = 16,
   parameter TICK_CYCLES = `TICK_CYCLES
) (
   // Clock and reset
   input  wire         mclk_i,
   input  wire         srst_i,
   // Gauges
   input  wire [W-1:0] low_vac_i,
   input  wire         low_bad_i,
   input  wire [W-1:0] high_vac_i,
   input  wire         high_stat_bad_i,
   input  wire         high_val_bad_i,
   input  wire [W-1:0] backing_vac_i,
   // Pumps
   input  wire         rough_start_i,
   input  wire         pumps_off_i,
   input  wire         leak_start_i,
   // Configuration
   input  wire         enable_sel_i,
   input  wire [W-1:0] turn_on_level_i,
   input  wire [W-1:0] turn_off_level_i,
   input  wire [1:0]   rough_src_i,
   input  wire [W-1:0] rough_target_i,
   input  wire [15:0]  rough_ticks_i,
   input  wire [1:0]   leak_src_i,
   input  wire [15:0]  leak_ticks_i,
   input  wire [W-1:0] leak_limit_i,
   input  wire [W-1:0] switch_lo_i,
   input  wire [W-1:0] switch_hi_i,
   input  wire [W-1:0] min_vac_i,
   input  wire [W-1:0] max_vac_i,
   // Status and display
   output reg          fault_o,
   output reg          sensor_break_o,
   output reg          gauge_enable_o,
   output reg          rough_timeout_o,
   output reg          roughing_timeout_lamp_o,
   output reg          leak_fault_o,
   output reg          leak_test_lamp_o,
   output reg  [W-1:0] leak_rate_o,
   output reg  [W-1:0] chamber_vac_o
);

   ////////////////////////////////////////////////////////////////////////
   // Hysteresis setpoint
   function hyst;
      input [W-1:0] val;
      input [W-1:0] on_l;
      input [W-1:0] off_l;
      input         cur;
      begin
         if (on_l > off_l)
            hyst = (val > on_l) ? 1'b1 : ((val < off_l) ? 1'b0 : cur);
         else
            hyst = (val < on_l) ? 1'b1 : ((val > off_l) ? 1'b0 : cur);
      end
   endfunction

   function [W-1:0] pick_src;
      input [1:0] sel;
      begin
         pick_src = (sel == `SRC_BACKING) ? backing_vac_i : low_vac_i;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Tick and flash
   reg [31:0] tick_cnt;
   reg        tick;
   reg [15:0] flash_cnt;
   reg        flash;

   always @(posedge mclk_i) begin
      if (srst_i) begin
         tick_cnt  <= 32'h0;
         tick      <= 1'b0;
         flash_cnt <= 16'h0;
         flash     <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (tick_cnt == TICK_CYCLES - 1) begin // R17
            tick_cnt <= 32'h0;
            tick     <= 1'b1;
         end else begin
            tick_cnt <= tick_cnt + 32'h1;
         end
         if (tick) begin
            if (flash_cnt == `FLASH_TICKS - 1) begin // R17
               flash_cnt <= 16'h0;
               flash     <= ~flash;
            end else begin
               flash_cnt <= flash_cnt + 16'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // High gauge enable and fault
   wire [W-1:0] en_vac = (enable_sel_i == `EN_SEL_BACKING) ? backing_vac_i
                                                           : low_vac_i; // R4
   wire high_bad = high_stat_bad_i | high_val_bad_i;

   always @(posedge mclk_i) begin
      if (srst_i) begin
         gauge_enable_o <= `GAUGE_EN_RST; // R3
         fault_o        <= 1'b0;
         sensor_break_o <= 1'b0;
      end else begin
         gauge_enable_o <= hyst(en_vac, turn_on_level_i, turn_off_level_i,
                                gauge_enable_o); // R2 R16 R3
         fault_o        <= high_bad; // R1
         sensor_break_o <= high_bad; // R1
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Roughing timeout
   reg        rough_run;
   reg [15:0] rough_cnt;
   // Vacuum deepens as the reading falls
   wire rough_ok = pick_src(rough_src_i) <= rough_target_i; // R6

   always @(posedge mclk_i) begin
      if (srst_i) begin
         rough_run               <= 1'b0;
         rough_cnt               <= 16'h0;
         rough_timeout_o         <= 1'b0;
         roughing_timeout_lamp_o <= 1'b0;
      end else begin
         if (rough_start_i && rough_src_i != `SRC_NONE) begin
            rough_run       <= 1'b1;
            rough_cnt       <= 16'h0;
            rough_timeout_o <= 1'b0;
         end else if (rough_run && tick) begin
            if (rough_cnt >= rough_ticks_i) begin // R5
               rough_run       <= 1'b0;
               rough_timeout_o <= ~rough_ok;
            end else begin
               rough_cnt <= rough_cnt + 16'h1;
            end
         end
         if (rough_src_i == `SRC_NONE) // R15
            roughing_timeout_lamp_o <= 1'b0;
         else
            roughing_timeout_lamp_o <= rough_run ? flash : rough_timeout_o; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Leak detection
   reg        leak_run;
   reg [15:0] leak_cnt;
   reg [W-1:0] leak_base;
   wire [W-1:0] leak_vac = pick_src(leak_src_i);
   // Rise in pressure over the window, scaled to a minute
   wire [W-1:0] leak_rise = (leak_vac > leak_base) ? leak_vac - leak_base
                                                   : {W{1'b0}};
   wire [W+31:0] rate_wide = (leak_rise * `TICKS_PER_MIN) /
                             ((leak_cnt == 16'h0) ? 32'h1 : {16'h0, leak_cnt});
   // Saturate so a fast leak can never wrap round below the limit
   wire [W-1:0]  rate_sat  = (|rate_wide[W+31:W]) ? {W{1'b1}} : rate_wide[W-1:0];

   always @(posedge mclk_i) begin
      if (srst_i) begin
         leak_run         <= 1'b0;
         leak_cnt         <= 16'h0;
         leak_base        <= {W{1'b0}};
         leak_rate_o      <= {W{1'b0}};
         leak_fault_o     <= 1'b0;
         leak_test_lamp_o <= 1'b0;
      end else begin
         if (leak_start_i && pumps_off_i && leak_src_i != `SRC_NONE) begin
            leak_run     <= 1'b1;
            leak_cnt     <= 16'h0;
            leak_base    <= leak_vac;
            leak_fault_o <= 1'b0;
         end else if (leak_run && !pumps_off_i) begin
            // Pumping spoils the measurement
            leak_run <= 1'b0;
         end else if (leak_run && tick) begin
            leak_rate_o <= rate_sat; // R8
            if (leak_cnt >= leak_ticks_i) begin
               leak_run     <= 1'b0;
               leak_fault_o <= rate_sat > leak_limit_i; // R9
            end else begin
               leak_cnt <= leak_cnt + 16'h1;
            end
         end
         if (leak_src_i == `SRC_NONE) // R15
            leak_test_lamp_o <= 1'b0;
         else
            leak_test_lamp_o <= leak_fault_o | (leak_run & flash); // R10
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bumpless switchover, band switch_lo..switch_hi
   wire [W-1:0] span = (switch_hi_i > switch_lo_i) ? switch_hi_i - switch_lo_i
                                                   : {{(W-1){1'b0}}, 1'b1};
   wire [W-1:0] pos  = (low_vac_i > switch_lo_i) ? low_vac_i - switch_lo_i
                                                 : {W{1'b0}};
   wire [2*W-1:0] blend_num = low_vac_i * pos + high_vac_i * (span - pos);
   // Weighted mean of two W-bit readings always fits in W bits
   wire [2*W-1:0] blend_q   = blend_num / span;
   wire [W-1:0]   blend     = blend_q[W-1:0];
   reg  [W-1:0] next_chamber;

   always @* begin
      if (high_bad)
         next_chamber = low_vac_i; // R12
      else if (low_bad_i)
         next_chamber = high_vac_i; // R12
      else if (low_vac_i >= switch_hi_i)
         next_chamber = low_vac_i;
      else if (low_vac_i <= switch_lo_i)
         next_chamber = high_vac_i;
      else
         next_chamber = blend; // R11
      if (next_chamber < min_vac_i) // R14
         next_chamber = min_vac_i;
      else if (next_chamber > max_vac_i)
         next_chamber = max_vac_i;
   end

   always @(posedge mclk_i) begin
      if (srst_i)
         chamber_vac_o <= {W{1'b0}};
      else
         chamber_vac_o <= next_chamber;
   end

endmodule

`default_nettype wire

// >>> vac_sup_regs.vh
`ifndef VAC_SUP_REGS_VH
`define VAC_SUP_REGS_VH

// Source selects
`define SRC_NONE        2'h0
`define SRC_LOW         2'h1
`define SRC_BACKING     2'h2
// Enable source select
`define EN_SEL_LOW      1'h0
`define EN_SEL_BACKING  1'h1
// Timing
`define CLK_HZ          200000000
`define TICK_US         1000
`define TICK_CYCLES     ((`CLK_HZ / 1000000) * `TICK_US)
`define FLASH_TICKS     250
`define TICKS_PER_MIN   60000
// Reset values
`define GAUGE_EN_RST    1'h0

`endif

// >>> vacuum_chamber_supervisor_properties.sv
`timescale 1ns/100ps
`default_nettype none
module vac_sup_props #(parameter W = 16) (
   input wire         mclk_i,
   input wire         srst_i,
   input wire [W-1:0] low_vac_i,
   input wire         low_bad_i,
   input wire [W-1:0] high_vac_i,
   input wire         high_stat_bad_i,
   input wire         high_val_bad_i,
   input wire [W-1:0] backing_vac_i,
   input wire         enable_sel_i,
   input wire [W-1:0] turn_on_level_i,
   input wire [W-1:0] turn_off_level_i,
   input wire [1:0]   rough_src_i,
   input wire [1:0]   leak_src_i,
   input wire [W-1:0] switch_lo_i,
   input wire [W-1:0] switch_hi_i,
   input wire [W-1:0] min_vac_i,
   input wire [W-1:0] max_vac_i,
   input wire         fault_o,
   input wire         sensor_break_o,
   input wire         gauge_enable_o,
   input wire         rough_timeout_o,
   input wire         roughing_timeout_lamp_o,
   input wire         leak_fault_o,
   input wire         leak_test_lamp_o,
   input wire [W-1:0] chamber_vac_o
);
   wire         hb = high_stat_bad_i | high_val_bad_i;
   wire [W-1:0] ev = enable_sel_i ? backing_vac_i : low_vac_i;
   wire         hy = turn_on_level_i > turn_off_level_i;
   wire lin = !low_bad_i && low_vac_i >= min_vac_i && low_vac_i <= max_vac_i;
   wire hin = !hb && high_vac_i >= min_vac_i && high_vac_i <= max_vac_i;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   brk_flag_a: assert property (hb |=> fault_o && sensor_break_o) else $error("no fault");
   en_on_a: assert property (hy && ev > turn_on_level_i |=> gauge_enable_o) else $error("no on");
   en_off_a: assert property (hy && ev < turn_off_level_i |=> !gauge_enable_o) else $error("no off");
   en_hold_a: assert property (hy && ev >= turn_off_level_i && ev <= turn_on_level_i
      |=> $stable(gauge_enable_o)) else $error("enable moved");
   clamp_a: assert property (min_vac_i <= max_vac_i |=> chamber_vac_o >= $past(min_vac_i)
      && chamber_vac_o <= $past(max_vac_i)) else $error("out of range");
   low_pick_a: assert property (low_vac_i > switch_hi_i && lin
      |=> chamber_vac_o == $past(low_vac_i)) else $error("low gauge not used");
   high_pick_a: assert property (low_vac_i < switch_lo_i && hin
      |=> chamber_vac_o == $past(high_vac_i)) else $error("high gauge not used");
   rough_lamp_a: assert property (rough_timeout_o && rough_src_i != 2'h0
      |=> roughing_timeout_lamp_o) else $error("timeout lamp off");
   leak_lamp_a: assert property (leak_fault_o && leak_src_i != 2'h0
      |=> leak_test_lamp_o) else $error("leak lamp off");
   cover property ($rose(gauge_enable_o));
   cover property ($rose(rough_timeout_o));
   cover property ($rose(leak_fault_o));
endmodule
bind vacuum_chamber_supervisor vac_sup_props #(.W(W)) i_chk (.*);
`default_nettype wire

// >>> gauge_model.sv
`timescale 1ns/100ps
`default_nettype none
module gauge_model (
   // Pressure at the gauges
   input  wire logic [15:0] p_i,
   input  wire logic [15:0] back_i,
   input  wire logic        brk_i,
   input  wire logic        pwr_i,
   // Gauge readings
   output logic      [15:0] low_o,
   output logic      [15:0] high_o,
   output logic      [15:0] back_o,
   output logic             stat_bad_o,
   output logic             val_bad_o
);
   assign low_o = p_i;
   assign back_o = back_i;
   // Unpowered high gauge shows garbage, never its last reading
   // Powered high gauge reads a little above the low one, so a blend shows
   assign high_o = pwr_i ? p_i + 16'h0010 : ~p_i;
   assign val_bad_o = !pwr_i;
   assign stat_bad_o = brk_i;
endmodule
`default_nettype wire

// >>> vacuum_chamber_supervisor_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "vac_sup_regs.vh"
module vacuum_chamber_supervisor_tb;
   logic        mclk_i = 0, srst_i = 1, brk = 0, lbad = 0, rs = 0, poff = 0, ls = 0, esel = 0;
   logic [15:0] p = 16'h0800, back = 16'h0000, rt = 16'h0200, lim = 16'h0010;
   // Gauge powers up on the way down, well before the bottom of the band
   logic [15:0] on_l = 16'h0280, off_l = 16'h0400;
   logic [15:0] rtk = 16'h0003, ltk = 16'h0003;
   logic [1:0]  rsrc = `SRC_LOW, lsrc = `SRC_NONE;
   wire  [15:0] lv, hv, bv, rate, ch;
   wire         sb, vb, flt, sbk, gen, rto, rl, lf, ll;
   int          n_errors = 0, total_checks = 0;
   logic [15:0] rows [8][3] = '{'{16'h0800, 16'h0, 16'h0800}, '{16'h0500, 16'h0, 16'h0500},
      '{16'h0300, 16'h0, 16'h0300}, '{16'h0100, 16'h1, 16'h0110},
      '{16'h0300, 16'h1, 16'h0300}, '{16'h0250, 16'h1, 16'h025b},
      '{16'h0050, 16'h1, 16'h0100}, '{16'h1000, 16'h0, 16'h0f00}};
   gauge_model i_gm (.p_i(p), .back_i(back), .brk_i(brk), .pwr_i(gen), .low_o(lv),
      .high_o(hv), .back_o(bv), .stat_bad_o(sb), .val_bad_o(vb));
   vacuum_chamber_supervisor #(.TICK_CYCLES(10)) i_dut (.mclk_i(mclk_i), .srst_i(srst_i),
      .low_vac_i(lv), .low_bad_i(lbad), .high_vac_i(hv), .high_stat_bad_i(sb),
      .high_val_bad_i(vb), .backing_vac_i(bv), .rough_start_i(rs), .pumps_off_i(poff),
      .leak_start_i(ls), .enable_sel_i(esel), .turn_on_level_i(on_l), .turn_off_level_i(off_l),
      .rough_src_i(rsrc), .rough_target_i(rt), .rough_ticks_i(rtk), .leak_src_i(lsrc),
      .leak_ticks_i(ltk), .leak_limit_i(lim), .switch_lo_i(16'h0200),
      .switch_hi_i(16'h0300), .min_vac_i(16'h0100), .max_vac_i(16'h0f00), .fault_o(flt),
      .sensor_break_o(sbk), .gauge_enable_o(gen), .rough_timeout_o(rto),
      .roughing_timeout_lamp_o(rl), .leak_fault_o(lf), .leak_test_lamp_o(ll),
      .leak_rate_o(rate), .chamber_vac_o(ch));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // One start pulse, then long enough for a three-tick timeout
   task automatic go(input logic r);
      rs = r;
      ls = !r;
      @(negedge mclk_i);
      rs = 0;
      ls = 0;
      repeat (80) @(negedge mclk_i);
   endtask
   initial begin
      forever #2.5 mclk_i = ~mclk_i;
   end
   initial begin
      #200000;
      n_errors++;
      end_sim;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge mclk_i);
      chk("gen_rst", gen, 0);
      srst_i = 0;
      foreach (rows[i]) begin
         p = rows[i][0];
         repeat (4) @(negedge mclk_i);
         chk("gen", gen, rows[i][1]);
         chk("chamber", ch, rows[i][2]);
      end
      p = 16'h0100;
      repeat (3) @(negedge mclk_i);
      chk("sbrk_good", sbk, 0);
      brk = 1;
      repeat (3) @(negedge mclk_i);
      chk("sbrk", sbk, 1);
      chk("fault", flt, 1);
      chk("chamber_brk", ch, 16'h0100);
      brk = 0;
      lbad = 1;
      p = 16'h0300;
      repeat (3) @(negedge mclk_i);
      chk("chamber_lbad", ch, 16'h0310);
      lbad = 0;
      p = 16'h0800;
      go(1);
      chk("rto_miss", rto, 1);
      chk("sbrk_val", sbk, 1);
      chk("rlamp_miss", rl, 1);
      rsrc = `SRC_BACKING;
      back = 16'h0100;
      go(1);
      chk("rto_ok", rto, 0);
      chk("rlamp_ok", rl, 0);
      // Levels the other way round: on above off
      p = 16'h0100;
      on_l = 16'h0600;
      off_l = 16'h0400;
      repeat (3) @(negedge mclk_i);
      chk("gen_low", gen, 0);
      esel = `EN_SEL_BACKING;
      back = 16'h0800;
      repeat (3) @(negedge mclk_i);
      chk("gen_back", gen, 1);
      back = 16'h0500;
      repeat (3) @(negedge mclk_i);
      chk("gen_hold", gen, 1);
      back = 16'h0300;
      repeat (3) @(negedge mclk_i);
      chk("gen_off", gen, 0);
      poff = 1;
      go(0);
      chk("llamp_none", ll, 0);
      lsrc = `SRC_LOW;
      go(0);
      chk("lf_flat", lf, 0);
      chk("rate_flat", rate, 0);
      ls = 1;
      @(negedge mclk_i);
      ls = 0;
      repeat (15) @(negedge mclk_i);
      p = 16'h0101;
      repeat (80) @(negedge mclk_i);
      chk("lf_rise", lf, 1);
      chk("llamp_rise", ll, 1);
      chk("rate_rise", 16'(rate > lim), 1);
      lsrc = `SRC_NONE;
      repeat (2) @(negedge mclk_i);
      chk("llamp_gone", ll, 0);
      srst_i = 1;
      @(negedge mclk_i);
      chk("lf_rst", lf, 0);
      srst_i = 0;
      end_sim;
   end
endmodule
`default_nettype wire
